// ---- core/bpp_defines.svh ----
// Purpose: Constants for the backplane processor bus port
// Assumes: Included by bare name from the package and the port modules
// Notes:   Widths are the full backplane widths; narrow processors mask them
`ifndef BPP_DEFINES_SVH
`define BPP_DEFINES_SVH

`define BPP_ADDR_W        24
`define BPP_DATA_W        16
`define BPP_ADDR_MASK_8   24'h00ffff
`define BPP_ADDR_MASK_16  24'hffffff
`define BPP_LANE_MASK_8   16'h00ff
`define BPP_LANE_MASK_16  16'hffff
`define BPP_BOOT_ROM_BASE 24'h000000
`define BPP_IO_WIN_BASE   24'h00ff00
`define BPP_IO_WIN_MASK   24'hffff00
`define BPP_PAGE_RST      1'b0
`define BPP_SERIAL_IDLE   1'b1
`define BPP_STROBE_IDLE   1'b1

`endif

// ---- core/bpp_pkg.sv ----
// Purpose: Types shared by the backplane processor bus port
// Assumes: Constants come from bpp_defines.svh
// Notes:   One-hot bus cycle states
`include "bpp_defines.svh"

package bpp_pkg;

  typedef enum logic [7:0]
  {
    bpp_idle    = 8'h01,
    bpp_t1      = 8'h02,
    bpp_t2      = 8'h04,
    bpp_t3      = 8'h08,
    bpp_refresh = 8'h10,
    bpp_release = 8'h20,
    bpp_granted = 8'h40,
    bpp_spare   = 8'h80
  } bpp_state_t;

  typedef logic [`BPP_ADDR_W-1:0] bpp_addr_t;
  typedef logic [`BPP_DATA_W-1:0] bpp_data_t;

endpackage

// ---- core/bpp_nmi_edge.sv ----
// Purpose: Falling-edge catcher for the unmaskable interrupt input
// Assumes: Pin is synchronous to core_clk
// Notes:   A held low level gives one event only; the next needs a rising edge first
`timescale 1ns/100ps

module bpp_nmi_edge
(
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic nmi_n,
  input  wire logic nmi_ack,
  output logic      nmi_pending
);

  logic nmi_prev_n;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      nmi_prev_n <= 1'b1;
    else
      nmi_prev_n <= nmi_n;
  end

  // A new edge in the acknowledge cycle must not be lost
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      nmi_pending <= 1'b0;
    else if (nmi_prev_n && !nmi_n)
      nmi_pending <= 1'b1;
    else if (nmi_ack)
      nmi_pending <= 1'b0;
  end

endmodule

// ---- core/bpp_bus_port.sv ----
// Purpose: Processor-side port onto the 8/16-bit backplane
// Assumes: All backplane inputs are synchronous to core_clk; core gives one request at a time
// Notes:   Bus cycle pin outputs are registered from the next cycle state
`timescale 1ns/100ps
`include "bpp_defines.svh"

module bpp_bus_port
  import bpp_pkg::*;
#(
  parameter bit NATIVE_FAMILY = 1'b1,
  parameter bit WIDE_BUS      = 1'b0
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_write,
  input  wire logic                   req_io,
  input  wire logic                   req_fetch,
  input  wire logic [`BPP_ADDR_W-1:0] req_addr,
  input  wire logic [`BPP_DATA_W-1:0] req_wdata,
  output logic                        rsp_valid,
  output logic [`BPP_DATA_W-1:0]      rsp_rdata,
  input  wire logic                   refresh_req,
  input  wire logic [15:0]            refresh_addr,
  input  wire logic                   halt_enter,
  output logic                        halted,
  input  wire logic                   ram_page_set,
  input  wire logic                   ram_page_clear,
  output logic                        irq_level,
  output logic                        nmi_pending,
  input  wire logic                   nmi_ack,
  output logic                        bus_granted,
  input  wire logic                   uart_txd,
  output logic                        uart_rxd,
  input  wire logic                   uart2_txd,
  output logic                        uart2_rxd,
  output logic [`BPP_ADDR_W-1:0]      addr_out,
  output logic [`BPP_ADDR_W-1:0]      addr_oe,
  input  wire logic [`BPP_DATA_W-1:0] data_in,
  output logic [`BPP_DATA_W-1:0]      data_out,
  output logic [`BPP_DATA_W-1:0]      data_oe,
  output logic                        memory_cycle_strobe_n,
  output logic                        memory_cycle_strobe_oe,
  output logic                        io_cycle_strobe_n,
  output logic                        io_cycle_strobe_oe,
  output logic                        read_strobe_n,
  output logic                        read_strobe_oe,
  output logic                        write_strobe_n,
  output logic                        write_strobe_oe,
  output logic                        opcode_fetch_cycle_n,
  output logic                        dram_refresh_cycle_n,
  output logic                        bus_grant_ack_n,
  output logic                        halt_n,
  output logic                        rom_shadow_select,
  input  wire logic                   bus_takeover_request_n,
  input  wire logic                   irq_request_n,
  input  wire logic                   nmi_n,
  input  wire logic                   wait_n,
  output logic                        serial_out,
  input  wire logic                   serial_in,
  output logic                        secondary_serial_out,
  input  wire logic                   secondary_serial_in
);

  bpp_state_t                state;
  bpp_state_t                next_state;
  logic                      cyc_write;
  logic                      cyc_io;
  logic                      cyc_fetch;
  logic [`BPP_ADDR_W-1:0]    cyc_addr;
  logic [`BPP_DATA_W-1:0]    cyc_wdata;
  logic                      accept;
  logic                      next_drive;
  logic                      next_xfer;
  logic                      next_write;
  logic                      next_io;
  logic                      next_fetch;
  logic [`BPP_ADDR_W-1:0]    next_addr;
  logic [`BPP_DATA_W-1:0]    next_wdata;

  // Processors without a separate I/O space see a memory window as I/O
  function automatic logic bpp_io_decode(input logic [`BPP_ADDR_W-1:0] addr, input logic io);
    if (NATIVE_FAMILY)
      bpp_io_decode = io;
    else
      bpp_io_decode = ((addr & `BPP_IO_WIN_MASK) == `BPP_IO_WIN_BASE);
  endfunction

  function automatic logic [`BPP_DATA_W-1:0] bpp_lane_mask();
    bpp_lane_mask = WIDE_BUS ? `BPP_LANE_MASK_16 : `BPP_LANE_MASK_8;
  endfunction

  function automatic logic [`BPP_ADDR_W-1:0] bpp_addr_mask();
    bpp_addr_mask = WIDE_BUS ? `BPP_ADDR_MASK_16 : `BPP_ADDR_MASK_8;
  endfunction

  // Takeover and refresh have priority over new core cycles
  assign req_ready = (state == bpp_idle) && bus_takeover_request_n && !refresh_req && !halted;
  assign accept    = req_valid && req_ready;

  always_comb
  begin
    next_state = state;
    case (state)
      bpp_idle:
      begin
        if (!bus_takeover_request_n)
          next_state = bpp_release;
        else if (refresh_req)
          next_state = bpp_refresh;
        else if (accept)
          next_state = bpp_t1;
      end
      bpp_t1:
        next_state = bpp_t2;
      bpp_t2:
      begin
        if (!wait_n)
          next_state = bpp_t2;
        else
          next_state = bpp_t3;
      end
      bpp_t3:
        next_state = bpp_idle;
      bpp_refresh:
        next_state = bpp_idle;
      bpp_release:
        next_state = bpp_granted;
      bpp_granted:
      begin
        if (bus_takeover_request_n)
          next_state = bpp_idle;
      end
      default:
        next_state = bpp_idle;
    endcase
  end

  assign next_xfer  = (next_state == bpp_t1) || (next_state == bpp_t2) || (next_state == bpp_t3);
  assign next_drive = next_xfer || (next_state == bpp_refresh);

  // Reset drops the port back to idle at once
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state <= bpp_idle;
    else
      state <= next_state;
  end

  // Pins load in the accepting edge, so the first cycle must see the new fields, not the held ones
  assign next_write = accept ? req_write : cyc_write;
  assign next_io    = accept ? bpp_io_decode(req_addr, req_io) : cyc_io;
  assign next_fetch = accept ? (req_fetch && !req_write) : cyc_fetch;
  assign next_addr  = accept ? (req_addr & bpp_addr_mask()) : cyc_addr;
  assign next_wdata = accept ? (req_wdata & bpp_lane_mask()) : cyc_wdata;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      {cyc_write, cyc_io, cyc_fetch, cyc_addr, cyc_wdata} <= '0;
    else
      {cyc_write, cyc_io, cyc_fetch, cyc_addr, cyc_wdata} <= {next_write, next_io, next_fetch, next_addr, next_wdata};
  end

  // Enables fall in the release cycle, the acknowledge one cycle later
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_oe                <= '0;
      data_oe                <= '0;
      memory_cycle_strobe_oe <= 1'b0;
      io_cycle_strobe_oe     <= 1'b0;
      read_strobe_oe         <= 1'b0;
      write_strobe_oe        <= 1'b0;
      bus_grant_ack_n        <= 1'b1;
    end
    else
    begin
      addr_oe                <= next_drive ? bpp_addr_mask() : '0;
      data_oe                <= (next_xfer && next_write) ? bpp_lane_mask() : '0;
      memory_cycle_strobe_oe <= next_drive;
      io_cycle_strobe_oe     <= next_drive;
      read_strobe_oe         <= next_drive;
      write_strobe_oe        <= next_drive;
      bus_grant_ack_n        <= !((next_state == bpp_granted) && (state == bpp_release)) &&
                                !((next_state == bpp_granted) && (state == bpp_granted));
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_out <= '0;
      data_out <= '0;
    end
    else if (next_state == bpp_refresh)
      addr_out <= {8'h00, refresh_addr};
    else if (next_xfer)
    begin
      addr_out <= next_addr;
      data_out <= next_wdata;
    end
  end

  // Strobes stay idle high while driven outside an access
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memory_cycle_strobe_n <= `BPP_STROBE_IDLE;
      io_cycle_strobe_n     <= `BPP_STROBE_IDLE;
      read_strobe_n         <= `BPP_STROBE_IDLE;
      write_strobe_n        <= `BPP_STROBE_IDLE;
      opcode_fetch_cycle_n  <= `BPP_STROBE_IDLE;
      dram_refresh_cycle_n  <= `BPP_STROBE_IDLE;
    end
    else
    begin
      memory_cycle_strobe_n <= !(((next_state == bpp_t1) || (next_state == bpp_t2)) && !next_io);
      io_cycle_strobe_n     <= !(((next_state == bpp_t1) || (next_state == bpp_t2)) && next_io);
      read_strobe_n         <= !(((next_state == bpp_t1) || (next_state == bpp_t2)) && !next_write);
      write_strobe_n        <= !((next_state == bpp_t2) && next_write);
      opcode_fetch_cycle_n  <= NATIVE_FAMILY ? !((next_state == bpp_t1) && next_fetch) : 1'b1;
      dram_refresh_cycle_n  <= !(next_state == bpp_refresh);
    end
  end

  // Read data is caught on the last wait-free edge, then handed back once
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state == bpp_t2) && wait_n;
      if ((state == bpp_t2) && wait_n && !cyc_write)
        rsp_rdata <= data_in & bpp_lane_mask();
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      bus_granted <= 1'b0;
    else
      bus_granted <= (next_state == bpp_granted);
  end

  // Halt entry wins over a resume seen in the same cycle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      halted <= 1'b0;
    else if (halt_enter)
      halted <= 1'b1;
    else if (!irq_request_n || nmi_pending)
      halted <= 1'b0;
  end

  assign halt_n = !halted;

  // The shared line is only read here; other modules pull it low
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      irq_level <= 1'b0;
    else
      irq_level <= !irq_request_n;
  end

  bpp_nmi_edge u_nmi
  (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .nmi_n       (nmi_n),
    .nmi_ack     (nmi_ack),
    .nmi_pending (nmi_pending)
  );

  // Low after reset so boot ROM decodes from the bottom of memory
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rom_shadow_select <= `BPP_PAGE_RST;
    else if (ram_page_set)
      rom_shadow_select <= 1'b1;
    else if (ram_page_clear)
      rom_shadow_select <= 1'b0;
  end

  // Serial lines idle at mark; one register stage each way
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_out           <= `BPP_SERIAL_IDLE;
      secondary_serial_out <= `BPP_SERIAL_IDLE;
      uart_rxd             <= `BPP_SERIAL_IDLE;
      uart2_rxd            <= `BPP_SERIAL_IDLE;
    end
    else
    begin
      serial_out           <= uart_txd;
      secondary_serial_out <= uart2_txd;
      uart_rxd             <= serial_in;
      uart2_rxd            <= secondary_serial_in;
    end
  end

endmodule

// ---- bench/bpp_bus_port_assertions.sv ----
// Purpose: Concurrent checks on the backplane bus port pins
// Assumes: Sees only ports of bpp_bus_port; one clock domain
// Notes:   Bound to the port from the foot of this file
`timescale 1ns/100ps
`include "bpp_defines.svh"

module bpp_bus_port_assertions
  import bpp_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   rstn,
  input wire logic [`BPP_ADDR_W-1:0] addr_oe,
  input wire logic [`BPP_DATA_W-1:0] data_oe,
  input wire logic                   memory_cycle_strobe_n,
  input wire logic                   memory_cycle_strobe_oe,
  input wire logic                   io_cycle_strobe_n,
  input wire logic                   read_strobe_n,
  input wire logic                   write_strobe_n,
  input wire logic                   dram_refresh_cycle_n,
  input wire logic                   bus_grant_ack_n,
  input wire logic                   bus_granted,
  input wire logic                   nmi_n,
  input wire logic                   nmi_pending,
  input wire logic                   halt_n,
  input wire logic                   halted,
  input wire logic                   wait_n,
  input wire logic                   irq_request_n,
  input wire logic                   req_ready,
  input wire logic                   bus_takeover_request_n,
  input wire logic                   req_valid,
  input wire logic                   req_write,
  input wire logic                   req_io,
  input wire logic                   req_fetch,
  input wire logic                   opcode_fetch_cycle_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Read strobe seen in both t1 and t2
  sequence rd_t2;
    !read_strobe_n ##1 !read_strobe_n;
  endsequence

  AST_GRANT_FLOAT: assert property (!bus_grant_ack_n |->
    addr_oe == '0 && data_oe == '0 && !memory_cycle_strobe_oe)
    else $error("grant shown while bus driven");
  AST_GRANT_AFTER_RELEASE: assert property ($fell(bus_grant_ack_n) |-> $past(addr_oe) == '0 && bus_granted)
    else $error("grant without prior release");
  AST_NMI_EDGE: assert property ($fell(nmi_n) |-> ##[1:2] nmi_pending)
    else $error("falling edge not taken");
  AST_MEM_ADDR: assert property (!memory_cycle_strobe_n |-> addr_oe[15:0] == 16'hffff && dram_refresh_cycle_n)
    else $error("memory strobe without address");
  AST_STROBE_EXCL: assert property (!(!memory_cycle_strobe_n && !io_cycle_strobe_n))
    else $error("memory and io strobes together");
  AST_REFRESH_ONLY: assert property (!dram_refresh_cycle_n |->
    memory_cycle_strobe_n && read_strobe_n && write_strobe_n)
    else $error("refresh overlaps access");
  AST_RW_EXCL: assert property (!write_strobe_n |-> read_strobe_n && data_oe[7:0] == 8'hff)
    else $error("store strobe without data");
  AST_WAIT_STRETCH: assert property (rd_t2 ##0 !wait_n |=> !read_strobe_n)
    else $error("wait not honoured");
  AST_HALT_HOLD: assert property (!halt_n && irq_request_n && !nmi_pending |=> !halt_n)
    else $error("halt left without interrupt");
  AST_NO_REQ_GRANTED: assert property (req_ready |-> bus_takeover_request_n && !halted)
    else $error("ready while halted or taken over");
  // Native family only: the space flag alone picks the strobe
  AST_SPACE_SELECT: assert property (req_valid && req_ready |=>
    io_cycle_strobe_n == !$past(req_io) && memory_cycle_strobe_n == $past(req_io))
    else $error("wrong space strobe in first cycle");
  AST_FETCH_MARK: assert property (req_valid && req_ready |=>
    opcode_fetch_cycle_n == !($past(req_fetch) && !$past(req_write)))
    else $error("fetch indication wrong in first cycle");
endmodule

bind bpp_bus_port bpp_bus_port_assertions bpp_bus_port_assertions_inst
(
  .core_clk, .rstn, .addr_oe, .data_oe, .memory_cycle_strobe_n, .memory_cycle_strobe_oe, .io_cycle_strobe_n,
  .read_strobe_n, .write_strobe_n, .dram_refresh_cycle_n, .bus_grant_ack_n, .bus_granted, .nmi_n, .nmi_pending,
  .halt_n, .halted, .wait_n, .irq_request_n, .req_ready, .bus_takeover_request_n, .req_valid, .req_write, .req_io,
  .req_fetch, .opcode_fetch_cycle_n
);

// ---- bench/bpp_backplane_model.sv ----
// Purpose: Memory and I/O module on the backplane
// Assumes: Strobes come from the bus port, synchronous to core_clk
// Notes:   256 words decoded from the low address byte
`timescale 1ns/100ps

module bpp_backplane_model
  import bpp_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic [3:0] wait_cycles,
  input  wire bpp_addr_t addr_out,
  input  wire bpp_data_t data_out,
  input  wire logic      memory_cycle_strobe_n,
  input  wire logic      io_cycle_strobe_n,
  input  wire logic      read_strobe_n,
  input  wire logic      write_strobe_n,
  output bpp_data_t      data_in,
  output logic           wait_n,
  input  wire logic      irq_chain_in,
  input  wire logic      irq_raise_n,
  input  wire logic      dma_grant_chain_in,
  output logic           irq_chain_out,
  output logic           dma_grant_chain_out
);
  bpp_data_t   mem [256];
  bpp_data_t   last = '0;
  logic [3:0]  cnt = '0;
  wire         active = !memory_cycle_strobe_n || !io_cycle_strobe_n;

  // Released bus toggles so a stale value never passes
  assign data_in = (active && !read_strobe_n) ? mem[addr_out[7:0]] : ~last;
  assign wait_n  = !(active && cnt != 0 && cnt <= wait_cycles);

  // Sits in a direct chain position: the DMA grant passes straight on
  assign dma_grant_chain_out = dma_grant_chain_in;
  assign irq_chain_out       = irq_chain_in && irq_raise_n;

  always_ff @(posedge core_clk)
  begin
    last <= data_in;
    cnt  <= active ? cnt + 4'h1 : 4'h0;
    if (active && !write_strobe_n)
      mem[addr_out[7:0]] <= data_out;
  end
endmodule

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the backplane bus port
// Assumes: Narrow bus, native family
// Notes:   Read results are checked from a queue by a monitor
`timescale 1ns/100ps
`include "bpp_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end

module testbench
  import bpp_pkg::*;
;
  logic core_clk = 0, rstn = 0, req_valid, req_write, req_io, req_fetch, refresh_req, halt_enter, ram_page_set;
  logic ram_page_clear, nmi_ack, uart_txd, uart2_txd, serial_in, secondary_serial_in, bus_takeover_request_n;
  logic irq_request_n, nmi_n, req_ready, rsp_valid, halted, irq_level, nmi_pending, bus_granted, uart_rxd;
  logic uart2_rxd, memory_cycle_strobe_n, memory_cycle_strobe_oe, io_cycle_strobe_n, io_cycle_strobe_oe;
  logic read_strobe_n, read_strobe_oe, write_strobe_n, write_strobe_oe, opcode_fetch_cycle_n, wait_n;
  logic dram_refresh_cycle_n, bus_grant_ack_n, halt_n, rom_shadow_select, serial_out, secondary_serial_out;
  bpp_addr_t   req_addr, addr_out, addr_oe, a;
  bpp_data_t   req_wdata, rsp_rdata, data_in, data_out, data_oe, d;
  logic        chain_irq, chain_dma;
  logic [15:0] refresh_addr;
  logic [3:0]  waits = '0;
  logic [16:0] exp_q [$];
  logic [16:0] exp;
  int          error_cnt = 0, n_tests = 0, cyc_cnt = 0, i, k;

  bpp_bus_port bpp_bus_port_inst (.*);
  bpp_backplane_model bpp_backplane_model_inst (.core_clk, .wait_cycles(waits), .addr_out, .data_out,
    .memory_cycle_strobe_n, .io_cycle_strobe_n, .read_strobe_n, .write_strobe_n, .data_in, .wait_n,
    .irq_chain_in(1'b1), .irq_raise_n(irq_request_n), .dma_grant_chain_in(bus_grant_ack_n),
    .irq_chain_out(chain_irq), .dma_grant_chain_out(chain_dma));

  initial forever #20 core_clk = ~core_clk;

  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic finish_test();
    if (exp_q.size() != 0)
      error_cnt++;
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Request held until the edge that sees ready
  task automatic cyc(logic w, logic io, logic f, bpp_addr_t ad, bpp_data_t wd, logic chk, bpp_data_t e);
    int n;
    {req_valid, req_write, req_io, req_fetch, req_addr, req_wdata} = {1'b1, w, io, f, ad, wd};
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      tick();
      n++;
    end
    if (n == 50)
      error_cnt++;
    exp_q.push_back({chk, e});
    tick();
    req_valid = 0;
    tick();
  endtask

  always
  begin
    @(posedge core_clk);
    #1;
    if (rsp_valid === 1'b1)
    begin
      exp = exp_q.pop_front();
      if (exp[16])
        `CHK(rsp_rdata, exp[15:0])
    end
  end

  always @(posedge core_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    {req_valid, req_write, req_io, req_fetch, refresh_req, halt_enter, ram_page_set, ram_page_clear} = '0;
    {nmi_ack, uart_txd, uart2_txd, serial_in, secondary_serial_in, req_addr, req_wdata, refresh_addr} = '0;
    {bus_takeover_request_n, irq_request_n, nmi_n} = 3'b111;
    void'($urandom(32'h9d0c));
    tick(6);
    rstn = 1;
    tick();
    `CHK(rom_shadow_select, 1'b0)
    for (i = 0; i < 16; i++)
    begin
      waits = 4'(i % 4);
      a = {16'h0012, 8'(i * 7)};
      d = 16'($urandom);
      cyc(1, 0, 0, a, d, 0, '0);
      cyc(0, i[0], i[1], a, '0, 1, d & `BPP_LANE_MASK_8);
    end
    tick(8);
    refresh_addr = 16'($urandom);
    refresh_req = 1;
    for (k = 0; dram_refresh_cycle_n !== 1'b0 && k < 20; k++)
      tick();
    `CHK(addr_out, {8'h00, refresh_addr})
    refresh_req = 0;
    tick(2);
    bus_takeover_request_n = 0;
    for (k = 0; bus_grant_ack_n !== 1'b0 && k < 20; k++)
      tick();
    `CHK({bus_granted, addr_oe, data_oe, chain_dma, io_cycle_strobe_oe, read_strobe_oe, write_strobe_oe}, 45'h1 << 44)
    bus_takeover_request_n = 1;
    tick(3);
    `CHK(bus_grant_ack_n, 1'b1)
    nmi_n = 0;
    tick(3);
    `CHK(nmi_pending, 1'b1)
    nmi_ack = 1;
    tick();
    nmi_ack = 0;
    tick(3);
    `CHK(nmi_pending, 1'b0)
    nmi_n = 1;
    halt_enter = 1;
    tick();
    halt_enter = 0;
    tick(3);
    `CHK({halt_n, req_ready}, 2'b00)
    irq_request_n = 0;
    tick(2);
    `CHK({halt_n, irq_level, chain_irq}, 3'b110)
    irq_request_n = 1;
    ram_page_set = 1;
    tick();
    ram_page_set = 0;
    tick();
    `CHK(rom_shadow_select, 1'b1)
    ram_page_clear = 1;
    tick();
    ram_page_clear = 0;
    tick();
    `CHK(rom_shadow_select, 1'b0)
    for (i = 0; i < 4; i++)
    begin
      k = $urandom;
      {uart_txd, uart2_txd, serial_in, secondary_serial_in} = 4'(k);
      tick(2);
      `CHK({serial_out, secondary_serial_out, uart_rxd, uart2_rxd}, 4'(k))
    end
    {req_valid, req_addr} = {1'b1, 24'h001234};
    tick(2);
    rstn = 0;
    req_valid = 0;
    #1;
    `CHK({addr_oe, read_strobe_n, memory_cycle_strobe_oe, bus_grant_ack_n}, {24'h0, 3'b101})
    tick(2);
    rstn = 1;
    tick();
    `CHK({addr_oe, read_strobe_n, bus_grant_ack_n, rsp_valid, io_cycle_strobe_oe, read_strobe_oe}, {24'h0, 5'b11000})
    cyc(0, 0, 0, a, '0, 1, d & `BPP_LANE_MASK_8);
    tick(10);
    finish_test();
  end
endmodule
